// ==== verilog/acfg_top.sv ====
`timescale 1ns/100ps
`include "acfg_regs.svh"

module acfg_top
  import acfg_pkg::*;
#(
  parameter int W  = 16,  // Output sample width, 16 or 14
  parameter int DT = 5    // Output timing setting width
) (
  input  wire logic          sys_clk_i,              // System clock
  input  wire logic          resetn_i,               // Synchronous reset, active low
  input  wire logic          sen_n_i,                // Serial select, active low
  input  wire logic          sclk_i,                 // Serial clock
  input  wire logic          sdata_i,                // Serial data in
  output logic               sdout_o,                // Serial data out
  input  wire logic          control_pin_one_i,      // Power-down pin, channel A
  input  wire logic          control_pin_two_i,      // Power-down pin, channel B
  input  wire logic          chan_a_outclk_invert_i, // Requested clock invert A
  input  wire logic          chan_b_outclk_invert_i, // Requested clock invert B
  input  wire logic [DT-1:0] ddr_timing_i,           // Requested output timing
  input  wire logic          test_pattern_en_i,      // Send test pattern instead of samples
  input  wire logic [W-1:0]  chan_a_sample_i,        // Channel A sample, twos complement
  input  wire logic [W-1:0]  chan_b_sample_i,        // Channel B sample, twos complement
  output logic               chan_a_powerdown_o,     // Channel A powered down
  output logic               chan_b_powerdown_o,     // Channel B powered down
  output logic               standby_o,              // Both converters in standby
  output logic               chan_a_outclk_invert_o, // Effective clock invert A
  output logic               chan_b_outclk_invert_o, // Effective clock invert B
  output logic [DT-1:0]      ddr_timing_o,           // Effective output timing
  output logic [W-1:0]       chan_a_data_o,          // Channel A output word
  output logic [W-1:0]       chan_b_data_o           // Channel B output word
);

  // --------------------------------------------------------------------------
  // Local state type
  // --------------------------------------------------------------------------
  typedef struct packed {
    acfg_cfg_t     cfg;     // Configuration fields
    logic          pd_a;    // Effective power-down A
    logic          pd_b;    // Effective power-down B
    logic          stby;    // Standby
    logic          inv_a;   // Gated clock invert A
    logic          inv_b;   // Gated clock invert B
    logic [DT-1:0] timing;  // Gated output timing
    logic [W-1:0]  pat_a;   // Test pattern counter A
    logic [W-1:0]  pat_b;   // Test pattern counter B
    logic [W-1:0]  out_a;   // Output word A
    logic [W-1:0]  out_b;   // Output word B
  } acfg_top_t;

  acfg_top_t  q;       // Registered state
  acfg_top_t  d;       // Next state
  logic       wr;      // Serial write strobe
  logic [6:0] addr;    // Serial address
  logic [7:0] wdata;   // Serial write byte
  logic [7:0] rdata;   // Read-back byte

  // --------------------------------------------------------------------------
  // Functions
  // --------------------------------------------------------------------------
  // Gain coefficient, unity at 1 << frac bits
  function automatic logic [11:0] gain_coef(input logic [4:0] code);
    logic [11:0] c;
    c = `ACFG_GAIN_UNITY;
    case (code)
      5'h03:   c = 12'h32D;           // -2.0 dB
      5'h04:   c = 12'h35D;           // -1.5 dB
      5'h05:   c = 12'h390;           // -1.0 dB
      5'h06:   c = 12'h3C7;           // -0.5 dB
      5'h08:   c = 12'h43D;           // 0.5 dB
      5'h09:   c = 12'h47D;           // 1.0 dB
      5'h0A:   c = 12'h4C1;           // 1.5 dB
      5'h0B:   c = 12'h509;           // 2.0 dB
      5'h0C:   c = 12'h556;           // 2.5 dB
      5'h0D:   c = 12'h5A7;           // 3.0 dB
      5'h0E:   c = 12'h5FC;           // 3.5 dB
      5'h0F:   c = 12'h657;           // 4.0 dB
      5'h10:   c = 12'h6B7;           // 4.5 dB
      5'h11:   c = 12'h71D;           // 5.0 dB
      5'h12:   c = 12'h789;           // 5.5 dB
      5'h13:   c = 12'h7FB;           // 6.0 dB
      default: c = `ACFG_GAIN_UNITY;  // 0 dB and unused codes
    endcase
    return c;
  endfunction : gain_coef

  // Scale a signed sample, saturating at full scale
  function automatic logic [W-1:0] apply_gain(input logic [W-1:0] s, input logic [11:0] c);
    logic signed [W+12:0] p;
    logic signed [W+12:0] mx;
    logic signed [W+12:0] mn;
    mx = (W+13)'((2 ** (W - 1)) - 1);
    mn = -mx - (W+13)'(1);
    p  = $signed(s) * $signed({1'b0, c});
    p  = p >>> `ACFG_GAIN_FRAC;
    if (p > mx) begin
      p = mx;
    end else if (p < mn) begin
      p = mn;
    end
    return p[W-1:0];
  endfunction : apply_gain

  // Reverse bit order
  function automatic logic [W-1:0] bit_rev(input logic [W-1:0] v);
    logic [W-1:0] r;
    r = '0;
    for (int i = 0; i < W; i++) begin
      r[i] = v[W-1-i];
    end
    return r;
  endfunction : bit_rev

  // Format one channel word for the output bus
  function automatic logic [W-1:0] fmt_word(input logic [W-1:0] v, input acfg_cfg_t c);
    logic [W-1:0] r;
    r = v;
    if (c.offset_bin) begin
      r[W-1] = ~v[W-1];
    end
    return r;
  endfunction : fmt_word

  // Unpack configuration from the two register bytes
  function automatic acfg_cfg_t unpack_cfg(input logic [7:0] pfr, input logic [7:0] gfc);
    acfg_cfg_t c;
    c.pd_a         = pfr[`ACFG_PFR_PDA];
    c.pd_b         = pfr[`ACFG_PFR_PDB];
    c.standby      = pfr[`ACFG_PFR_STBY];
    c.offset_bin   = pfr[`ACFG_PFR_FMT];
    c.pin_override = pfr[`ACFG_PFR_OVR];
    c.pat_align    = pfr[`ACFG_PFR_ALN];
    c.gain_code    = gfc[`ACFG_GFC_GAIN_HI:`ACFG_GFC_GAIN_LO];
    c.gain_en      = gfc[`ACFG_GFC_GEN];
    c.flip         = gfc[`ACFG_GFC_FLIP];
    return c;
  endfunction : unpack_cfg

  // Read-back byte; reserved and reset bits read zero
  function automatic logic [7:0] read_byte(input logic [6:0] a, input acfg_cfg_t c);
    logic [7:0] r;
    r = `ACFG_RD_NONE;
    if (a == `ACFG_OFS_PFR) begin
      r[`ACFG_PFR_PDA]  = c.pd_a;
      r[`ACFG_PFR_PDB]  = c.pd_b;
      r[`ACFG_PFR_STBY] = c.standby;
      r[`ACFG_PFR_FMT]  = c.offset_bin;
      r[`ACFG_PFR_OVR]  = c.pin_override;
      r[`ACFG_PFR_ALN]  = c.pat_align;
    end else if (a == `ACFG_OFS_GFC) begin
      r[`ACFG_GFC_GAIN_HI:`ACFG_GFC_GAIN_LO] = c.gain_code;
      r[`ACFG_GFC_GEN]  = c.gain_en;
      r[`ACFG_GFC_FLIP] = c.flip;
    end
    return r;
  endfunction : read_byte

  // --------------------------------------------------------------------------
  // Serial front end
  // --------------------------------------------------------------------------
  acfg_serial u_serial (
    .sys_clk_i (sys_clk_i),
    .resetn_i  (resetn_i),
    .sen_n_i   (sen_n_i),
    .sclk_i    (sclk_i),
    .sdata_i   (sdata_i),
    .rdata_i   (rdata),
    .sdout_o   (sdout_o),
    .wr_o      (wr),
    .addr_o    (addr),
    .wdata_o   (wdata)
  );

  assign rdata = read_byte(addr, q.cfg);

  // --------------------------------------------------------------------------
  // Register writes and data path
  // --------------------------------------------------------------------------
  always_comb begin
    logic [W-1:0] a;
    logic [W-1:0] b;
    logic         sel_a;
    logic         sel_b;
    a     = chan_a_sample_i;
    b     = chan_b_sample_i;
    sel_a = 1'b0;
    sel_b = 1'b0;
    d     = q;

    // Writes; reserved bit one is never stored
    if (wr && (addr == `ACFG_OFS_PFR)) begin
      d.cfg = unpack_cfg(wdata, read_byte(`ACFG_OFS_GFC, q.cfg));
      if (wdata[`ACFG_PFR_SRST]) begin
        // Reset bit is not stored, so it reads back zero
        d.cfg = unpack_cfg(`ACFG_PFR_RST, `ACFG_GFC_RST);
      end
    end else if (wr && (addr == `ACFG_OFS_GFC)) begin
      d.cfg = unpack_cfg(read_byte(`ACFG_OFS_PFR, q.cfg), wdata);
    end

    // Power-down source: pins or register field
    if (q.cfg.pin_override) begin
      sel_a = q.cfg.pd_a;
      sel_b = q.cfg.pd_b;
    end else begin
      sel_a = control_pin_one_i;
      sel_b = control_pin_two_i;
    end
    d.stby = q.cfg.standby;
    d.pd_a = sel_a | q.cfg.standby;
    d.pd_b = sel_b | q.cfg.standby;

    // Clock invert and timing only pass under override
    d.inv_a  = q.cfg.pin_override & chan_a_outclk_invert_i;
    d.inv_b  = q.cfg.pin_override & chan_b_outclk_invert_i;
    d.timing = q.cfg.pin_override ? ddr_timing_i : '0;

    // Test pattern ramps; aligned mode locks B to A
    d.pat_a = q.pat_a + W'(1);
    d.pat_b = q.cfg.pat_align ? d.pat_a : q.pat_b + W'(1);

    // Channel A gain
    if (q.cfg.gain_en) begin
      a = apply_gain(a, gain_coef(q.cfg.gain_code));
    end
    a = fmt_word(a, q.cfg);
    b = fmt_word(b, q.cfg);
    if (test_pattern_en_i) begin
      a = q.pat_a;
      b = q.pat_b;
    end
    // Optional bus reversal
    if (q.cfg.flip) begin
      a = bit_rev(a);
      b = bit_rev(b);
    end
    d.out_a = q.pd_a ? '0 : a;
    d.out_b = q.pd_b ? '0 : b;
  end

  // --------------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      q     <= '0;
      q.cfg <= unpack_cfg(`ACFG_PFR_RST, `ACFG_GFC_RST);
    end else begin
      q <= d;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign chan_a_powerdown_o     = q.pd_a;
  assign chan_b_powerdown_o     = q.pd_b;
  assign standby_o              = q.stby;
  assign chan_a_outclk_invert_o = q.inv_a;
  assign chan_b_outclk_invert_o = q.inv_b;
  assign ddr_timing_o           = q.timing;
  assign chan_a_data_o          = q.out_a;
  assign chan_b_data_o          = q.out_b;

endmodule : acfg_top

// ==== verilog/acfg_regs.svh ====
`ifndef ACFG_REGS_SVH
`define ACFG_REGS_SVH

// ----------------------------------------------------------------------------
// Serial frame layout
// ----------------------------------------------------------------------------
`define ACFG_ADDR_W       7
`define ACFG_DATA_W       8
`define ACFG_CNT_LAST     4'h7
`define ACFG_CNT_ONE      4'h1
`define ACFG_CNT_ZERO     4'h0

// ----------------------------------------------------------------------------
// Register offsets and reset values
// ----------------------------------------------------------------------------
`define ACFG_OFS_PFR      7'h08
`define ACFG_OFS_GFC      7'h0B
`define ACFG_PFR_RST      8'h00
`define ACFG_GFC_RST      8'h00
`define ACFG_RD_NONE      8'h00

// ----------------------------------------------------------------------------
// Field positions, power_format_reset_ctrl
// ----------------------------------------------------------------------------
`define ACFG_PFR_PDA      7
`define ACFG_PFR_PDB      6
`define ACFG_PFR_STBY     5
`define ACFG_PFR_FMT      4
`define ACFG_PFR_OVR      3
`define ACFG_PFR_ALN      2
`define ACFG_PFR_SRST     0

// ----------------------------------------------------------------------------
// Field positions, chan_a_gain_flip_ctrl
// ----------------------------------------------------------------------------
`define ACFG_GFC_GAIN_HI  7
`define ACFG_GFC_GAIN_LO  3
`define ACFG_GFC_GEN      2
`define ACFG_GFC_FLIP     0

// ----------------------------------------------------------------------------
// Digital gain arithmetic
// ----------------------------------------------------------------------------
`define ACFG_GAIN_FRAC    10
`define ACFG_GAIN_UNITY   12'h400

`endif

// ==== verilog/acfg_pkg.sv ====
package acfg_pkg;

  // --------------------------------------------------------------------------
  // Serial front-end states
  // --------------------------------------------------------------------------
  typedef enum logic [3:0] {
    ACFG_S_IDLE = 4'h1,   // Waiting for select
    ACFG_S_CMD  = 4'h2,   // Shifting direction and address
    ACFG_S_DATA = 4'h4,   // Shifting data byte
    ACFG_S_DONE = 4'h8    // Frame over, waiting for deselect
  } acfg_sstate_t;

  // --------------------------------------------------------------------------
  // Serial front-end state
  // --------------------------------------------------------------------------
  typedef struct packed {
    acfg_sstate_t st;        // Frame state
    logic         sclk_prev; // Previous serial clock level
    logic [3:0]   cnt;       // Bits taken in current phase
    logic         rnw;       // Read when set
    logic [6:0]   shift;     // Incoming bits
    logic [6:0]   addr;      // Captured address
    logic [7:0]   tx;        // Outgoing read bits
    logic         sdout;     // Serial data out
    logic         wr;        // One-cycle write strobe
    logic [7:0]   wdata;     // Written byte
  } acfg_ser_t;

  // --------------------------------------------------------------------------
  // Configuration fields
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic       pd_a;         // chan_a_powerdown
    logic       pd_b;         // chan_b_powerdown
    logic       standby;      // standby_bit
    logic       offset_bin;   // Output format
    logic       pin_override; // pin_override_bit
    logic       pat_align;    // pattern_align_bit
    logic [4:0] gain_code;    // chan_a_gain_code
    logic       gain_en;      // chan_a_gain_enable
    logic       flip;         // Output bus bit reversal
  } acfg_cfg_t;

endpackage : acfg_pkg

// ==== verilog/acfg_serial.sv ====
`timescale 1ns/100ps
`include "acfg_regs.svh"

module acfg_serial
  import acfg_pkg::*;
(
  input  wire logic       sys_clk_i,  // System clock
  input  wire logic       resetn_i,   // Synchronous reset, active low
  input  wire logic       sen_n_i,    // Serial select, active low
  input  wire logic       sclk_i,     // Serial clock
  input  wire logic       sdata_i,    // Serial data in
  input  wire logic [7:0] rdata_i,    // Read byte for addr_o
  output logic            sdout_o,    // Serial data out
  output logic            wr_o,       // Write strobe
  output logic [6:0]      addr_o,     // Register address
  output logic [7:0]      wdata_o     // Write byte
);

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  acfg_ser_t q;   // Registered state
  acfg_ser_t d;   // Next state
  logic      rise; // Serial clock rising edge
  logic      fall; // Serial clock falling edge

  // --------------------------------------------------------------------------
  // Frame decoder
  // --------------------------------------------------------------------------
  always_comb begin
    d      = q;
    rise   = sclk_i & ~q.sclk_prev;
    fall   = ~sclk_i & q.sclk_prev;
    d.sclk_prev = sclk_i;
    d.wr   = 1'b0;
    if (sen_n_i) begin
      // Deselect aborts any frame
      d.st    = ACFG_S_IDLE;
      d.cnt   = `ACFG_CNT_ZERO;
      d.sdout = 1'b0;
    end else begin
      unique case (q.st)
        ACFG_S_IDLE: begin
          d.st  = ACFG_S_CMD;
          d.cnt = `ACFG_CNT_ZERO;
        end
        ACFG_S_CMD: if (rise) begin
          // First bit is direction, then seven address bits
          if (q.cnt == `ACFG_CNT_ZERO) begin
            d.rnw = sdata_i;
          end
          d.shift = {q.shift[5:0], sdata_i};
          d.cnt   = q.cnt + `ACFG_CNT_ONE;
          if (q.cnt == `ACFG_CNT_LAST) begin
            d.addr = {q.shift[5:0], sdata_i};
            d.st   = ACFG_S_DATA;
            d.cnt  = `ACFG_CNT_ZERO;
          end
        end
        ACFG_S_DATA: begin
          // Read bits change on the falling edge
          if (fall) begin
            if (q.cnt == `ACFG_CNT_ZERO) begin
              d.sdout = rdata_i[7];
              d.tx    = {rdata_i[6:0], 1'b0};
            end else begin
              d.sdout = q.tx[7];
              d.tx    = {q.tx[6:0], 1'b0};
            end
          end
          if (rise) begin
            d.shift = {q.shift[5:0], sdata_i};
            d.cnt   = q.cnt + `ACFG_CNT_ONE;
            if (q.cnt == `ACFG_CNT_LAST) begin
              // Writes complete on the last data bit
              d.wr    = ~q.rnw;
              d.wdata = {q.shift, sdata_i};
              d.st    = ACFG_S_DONE;
            end
          end
        end
        ACFG_S_DONE: begin
          d.st = ACFG_S_DONE;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      q <= '{st: ACFG_S_IDLE, default: '0};
    end else begin
      q <= d;
    end
  end

  assign sdout_o = q.sdout;
  assign wr_o    = q.wr;
  assign addr_o  = q.addr;
  assign wdata_o = q.wdata;

endmodule : acfg_serial

// ==== dv/acfg_top_checker.sv ====
`timescale 1ns/100ps
module acfg_top_checker #(
  parameter int W  = 16, // Sample width
  parameter int DT = 5   // Timing width
) (
  input wire logic          sys_clk_i,              // System clock
  input wire logic          resetn_i,               // Reset, active low
  input wire logic          sen_n_i,                // Serial select, active low
  input wire logic          sdout_i,                // Serial data out
  input wire logic          control_pin_one_i,      // Pin request A
  input wire logic          chan_a_outclk_invert_i, // Requested invert A
  input wire logic          chan_b_outclk_invert_i, // Requested invert B
  input wire logic [DT-1:0] ddr_timing_i,           // Requested timing
  input wire logic          chan_a_powerdown_o,     // Channel A down
  input wire logic          chan_b_powerdown_o,     // Channel B down
  input wire logic          standby_o,              // Standby
  input wire logic          chan_a_outclk_invert_o, // Effective invert A
  input wire logic          chan_b_outclk_invert_o, // Effective invert B
  input wire logic [DT-1:0] ddr_timing_o,           // Effective timing
  input wire logic [W-1:0]  chan_a_data_o,          // Output word A
  input wire logic [W-1:0]  chan_b_data_o           // Output word B
);
  // ------------------------------------------------------------------
  // Clock and reset for every property
  // ------------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!resetn_i);
  // ------------------------------------------------------------------
  // Steps
  // ------------------------------------------------------------------
  sequence s_down_a;
    chan_a_powerdown_o [*3];
  endsequence
  sequence s_down_b;
    chan_b_powerdown_o [*3];
  endsequence
  sequence s_pins_rule;
    (chan_a_outclk_invert_i && !chan_a_outclk_invert_o && !standby_o && $stable(control_pin_one_i)) [*3];
  endsequence
  // ------------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------------
  property p_zero_a;
    s_down_a |-> chan_a_data_o == '0;
  endproperty
  property p_zero_b;
    s_down_b |-> chan_b_data_o == '0;
  endproperty
  property p_stby;
    standby_o [*2] |-> chan_a_powerdown_o && chan_b_powerdown_o;
  endproperty
  property p_pins;
    s_pins_rule |-> chan_a_powerdown_o == control_pin_one_i;
  endproperty
  property p_inv_a;
    chan_a_outclk_invert_o |-> $past(chan_a_outclk_invert_i);
  endproperty
  property p_inv_b;
    chan_b_outclk_invert_o |-> $past(chan_b_outclk_invert_i);
  endproperty
  property p_inv_same;
    $past(chan_a_outclk_invert_i) && $past(chan_b_outclk_invert_i)
      |-> chan_a_outclk_invert_o == chan_b_outclk_invert_o;
  endproperty
  property p_ddr;
    $past(chan_a_outclk_invert_i) && $past(ddr_timing_i) != '0 |-> (ddr_timing_o != '0) == chan_a_outclk_invert_o;
  endproperty
  property p_idle;
    sen_n_i [*2] |-> !sdout_i;
  endproperty
  a_zero_a: assert property (p_zero_a) else $error("Channel A word not zero while down");
  a_zero_b: assert property (p_zero_b) else $error("Channel B word not zero while down");
  a_stby: assert property (p_stby) else $error("Standby without both channels down");
  a_pins: assert property (p_pins) else $error("Channel A down differs from its pin");
  a_inv_a: assert property (p_inv_a) else $error("Invert A set without request");
  a_inv_b: assert property (p_inv_b) else $error("Invert B set without request");
  a_inv_same: assert property (p_inv_same) else $error("Invert outputs gated apart");
  a_ddr: assert property (p_ddr) else $error("Timing gated apart from invert");
  a_idle: assert property (p_idle) else $error("Serial out driven while deselected");
endmodule : acfg_top_checker

bind acfg_top acfg_top_checker #(.W(W), .DT(DT)) acfg_top_checker_inst (
  .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .sen_n_i(sen_n_i), .sdout_i(sdout_o),
  .control_pin_one_i(control_pin_one_i), .chan_a_outclk_invert_i(chan_a_outclk_invert_i),
  .chan_b_outclk_invert_i(chan_b_outclk_invert_i), .ddr_timing_i(ddr_timing_i),
  .chan_a_powerdown_o(chan_a_powerdown_o), .chan_b_powerdown_o(chan_b_powerdown_o), .standby_o(standby_o),
  .chan_a_outclk_invert_o(chan_a_outclk_invert_o), .chan_b_outclk_invert_o(chan_b_outclk_invert_o),
  .ddr_timing_o(ddr_timing_o), .chan_a_data_o(chan_a_data_o), .chan_b_data_o(chan_b_data_o));

// ==== dv/acfg_host.sv ====
`timescale 1ns/100ps
module acfg_host (
  input  wire logic sys_clk_i, // System clock
  input  wire logic sdout_i,   // Read bits from device
  output logic      sen_n_o,   // Select, active low
  output logic      sclk_o,    // Serial clock, idles low
  output logic      sdata_o    // Serial data
);
  // ------------------------------------------------------------------
  // Idle levels at time zero
  // ------------------------------------------------------------------
  initial begin
    sen_n_o = 1'b1;
    sclk_o  = 1'b0;
    sdata_o = 1'b0;
  end
  // One frame: direction, address, data, MSB first; read bits on rises
  task automatic frame(input logic rnw, input logic [6:0] addr, input logic [7:0] wd, output logic [7:0] rd);
    logic [15:0] bits;
    bits = {rnw, addr, wd};
    rd = 8'h00;
    @(posedge sys_clk_i);
    sen_n_o <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    for (int i = 15; i >= 0; i--) begin
      sdata_o <= bits[i];
      repeat (4) @(posedge sys_clk_i);
      sclk_o <= 1'b1;
      if (i < 8) rd = {rd[6:0], sdout_i};
      repeat (4) @(posedge sys_clk_i);
      sclk_o <= 1'b0;
    end
    repeat (2) @(posedge sys_clk_i);
    sen_n_o <= 1'b1;
    sdata_o <= ~sdata_o; // Released line does not keep its value
    repeat (2) @(posedge sys_clk_i);
  endtask : frame
endmodule : acfg_host

// ==== dv/tb_top.sv ====
`timescale 1ns/100ps
module tb_top;
  logic        clk = 1'b0, rstn, sen_n, sclk, sdata, sdout;          // Clock, reset, serial lines
  logic        pin_one, pin_two, inv_a, inv_b, tp_en, pd_a, pd_b, stby; // Pins and states
  logic        inv_a_o, inv_b_o;                                      // Effective inverts
  logic [4:0]  ddr_i, ddr_o;                                          // Timing in and out
  logic [15:0] sa, sb, da, db;                                        // Samples and words
  logic [7:0]  pfr_m, gfc_m;                                          // Register model
  logic [31:0] seed = 32'h0000_000D, r;                               // Random state
  logic [4:0]  gtab [4] = '{5'h00, 5'h03, 5'h07, 5'h13};              // Gain codes used
  int          num_errors = 0, check_count = 0, cycles = 0, ga;       // Counters, gain A
  always #10 clk = ~clk;
  acfg_host acfg_host_inst (.sys_clk_i(clk), .sdout_i(sdout), .sen_n_o(sen_n), .sclk_o(sclk), .sdata_o(sdata));
  acfg_top #(.W(16), .DT(5)) acfg_top_inst (
    .sys_clk_i(clk), .resetn_i(rstn), .sen_n_i(sen_n), .sclk_i(sclk), .sdata_i(sdata), .sdout_o(sdout),
    .control_pin_one_i(pin_one), .control_pin_two_i(pin_two), .chan_a_outclk_invert_i(inv_a),
    .chan_b_outclk_invert_i(inv_b), .ddr_timing_i(ddr_i), .test_pattern_en_i(tp_en), .chan_a_sample_i(sa),
    .chan_b_sample_i(sb), .chan_a_powerdown_o(pd_a), .chan_b_powerdown_o(pd_b), .standby_o(stby),
    .chan_a_outclk_invert_o(inv_a_o), .chan_b_outclk_invert_o(inv_b_o), .ddr_timing_o(ddr_o),
    .chan_a_data_o(da), .chan_b_data_o(db));
  // Compare one value, count it
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // Verdict and end of run
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : finish_test
  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      finish_test();
    end
  end
  // Register write, model follows
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] rd;
    acfg_host_inst.frame(1'b0, a, d, rd);
    if (a == 7'h08 && d[0]) begin
      pfr_m = 8'h00;
      gfc_m = 8'h00;
    end else if (a == 7'h08) pfr_m = d & 8'hFC;
    else if (a == 7'h0B) gfc_m = d & 8'hFD;
  endtask : wr
  // Register read against the model; unmapped reads zero
  task automatic rd_chk(input logic [6:0] a);
    logic [7:0] rd;
    acfg_host_inst.frame(1'b1, a, 8'h00, rd);
    check(rd, (a == 7'h08) ? pfr_m : (a == 7'h0B) ? gfc_m : 8'h00);
  endtask : rd_chk
  // Expected output word: gain, format, flip, power-down
  function automatic logic [15:0] dexp(input logic [15:0] s, input logic pd, input int coef);
    logic signed [31:0] v;
    logic [15:0] o;
    v = $signed(s) * coef;
    o = v[25:10];
    if (pfr_m[4]) o[15] = ~o[15];
    if (gfc_m[0]) o = {<<{o}};
    return pd ? 16'h0000 : o;
  endfunction : dexp
  // Settle, then compare every output except sdout_o with the model
  task automatic chk_out();
    logic pa, pb, ov;
    ov = pfr_m[3];
    pa = pfr_m[5] | (ov ? pfr_m[7] : pin_one);
    pb = pfr_m[5] | (ov ? pfr_m[6] : pin_two);
    repeat (4) @(posedge clk);
    #1;
    check(pd_a, pa);
    check(pd_b, pb);
    check(stby, pfr_m[5]);
    check({inv_a_o, inv_b_o}, {inv_a & ov, inv_b & ov});
    check(ddr_o, ov ? ddr_i : 5'h00);
    check(da, dexp(sa, pa, ga));
    check(db, dexp(sb, pb, 1024));
  endtask : chk_out
  // Next xorshift value
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction : xorshift
  // Main sequence
  initial begin
    {pin_one, pin_two, inv_a, inv_b, tp_en, rstn} = '0;
    {ddr_i, sa, sb, pfr_m, gfc_m} = '0;
    ga = 1024;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    rd_chk(7'h08);
    rd_chk(7'h0B);
    chk_out();
    $display("test reset values done");
    for (int i = 0; i < 8; i++) begin
      seed = xorshift(seed);
      r = seed;
      @(posedge clk);
      {pin_one, pin_two, inv_b, ddr_i} <= {r[0], r[1], r[3], r[8:4]};
      inv_a <= r[2] | ~i[2];
      wr(7'h0B, {gtab[i[1:0]], i[2], 1'b0, r[13]});
      wr(7'h08, {i[1:0], i == 6, r[14], i[2], r[15], 2'b00});
      ga = !gfc_m[2] ? 1024 : (gfc_m[7:3] == 5'h03) ? 813 : (gfc_m[7:3] == 5'h13) ? 2043 : 1024;
      sa <= (ga == 1024) ? r[31:16] : {{3{r[17]}}, r[17:16], r[18], 10'h000};
      sb <= r[31:16] ^ 16'h5A5A;
      rd_chk(7'h08);
      rd_chk(7'h0B);
      chk_out();
      $display("test setting %0d done", i);
    end
    wr(7'h08, 8'h12);
    wr(7'h0B, 8'h03);
    rd_chk(7'h08);
    rd_chk(7'h0B);
    wr(7'h05, 8'hFF);
    rd_chk(7'h05);
    rd_chk(7'h08);
    $display("test reserved and unmapped done");
    wr(7'h0B, 8'h00);
    wr(7'h08, 8'h0C);
    tp_en <= 1'b1;
    repeat (4) @(posedge clk);
    repeat (3) begin
      @(posedge clk);
      #1;
      check(db, da);
    end
    tp_en <= 1'b0;
    $display("test pattern align done");
    wr(7'h0B, 8'h9D);
    wr(7'h08, 8'hF9);
    rd_chk(7'h08);
    rd_chk(7'h0B);
    ga = 1024;
    chk_out();
    $display("test soft reset done");
    finish_test();
  end
endmodule : tb_top
